// ==== pfc_cutoff.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Cutoff touches only the six gated pins, and only when set as outputs.
// R2 - With motor control unused, each output pin drives its function.
// R3 - With motor control used and PWM output off, gated outputs float.
// R4 - With control used, PWM on and emergency input high, pins drive.
// R5 - With control used and PWM on, a low emergency input floats pins.
// R6 - A low emergency input clears PWM enable until software sets it.
// R7 - Hold reset, boot select low 2 ms past 2.7 V, raise select, then reset; the testbench holds select low for 3 clock edges only.
module pfc_cutoff (
    input  wire logic                clk,
    input  wire logic                rst,
    // avalon-mm slave
    input  wire logic [4:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    // peripheral output sources
    input  wire pfc_pkg::pfc_fn_src_s fn_src,
    // pins
    input  wire logic                nmi_n,
    input  wire logic [5:0]          pin_i,
    output logic      [5:0]          pin_o,
    output logic      [5:0]          pin_oe
);

    // =========================================================
    // decoding helpers
    function automatic logic is_out_fn(input logic [2:0] code);
        is_out_fn = (code == pfc_pkg::PFC_FN_PORT)   ||
                    (code == pfc_pkg::PFC_FN_TIMER)  ||
                    (code == pfc_pkg::PFC_FN_PWM)    ||
                    (code == pfc_pkg::PFC_FN_SERIAL) ||
                    (code == pfc_pkg::PFC_FN_IIO);
    endfunction : is_out_fn

    function automatic logic fn_value(input logic [2:0] code,
                                      input logic       port_bit,
                                      input logic       tmr,
                                      input logic       pwm,
                                      input logic       ser,
                                      input logic       iio);
        unique case (code)
            pfc_pkg::PFC_FN_PORT:   fn_value = port_bit;
            pfc_pkg::PFC_FN_TIMER:  fn_value = tmr;
            pfc_pkg::PFC_FN_PWM:    fn_value = pwm;
            pfc_pkg::PFC_FN_SERIAL: fn_value = ser;
            pfc_pkg::PFC_FN_IIO:    fn_value = iio;
            default:                fn_value = 1'b0;
        endcase
    endfunction : fn_value

    function automatic logic hit(input logic [4:0] addr,
                                 input logic [4:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // =========================================================
    // state
    pfc_pkg::pfc_state_s st_r;
    pfc_pkg::pfc_state_s st_nxt;

    logic [5:0] out_mask;
    logic [5:0] sel_val;
    logic       cutoff;
    logic       req;
    logic       wr_go;
    logic       rd_go;
    logic       ctrl_wr;
    logic       mapped;
    logic       wd_use;
    logic       wd_en;

    // =========================================================
    // per-pin function select
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_pin
            // output function only
            // R1 output pins only
            assign out_mask[gi] = st_r.dir[gi] &&
                is_out_fn(st_r.fsel[gi*3 +: 3]);
            assign sel_val[gi] = fn_value(st_r.fsel[gi*3 +: 3],
                                          st_r.pdata[gi],
                                          fn_src.timer[gi],
                                          fn_src.pwm[gi],
                                          fn_src.serial[gi],
                                          fn_src.iio[gi]);
        end
    endgenerate

    // =========================================================
    // cutoff decision
    // R3 disabled floats
    // R5 emergency floats
    assign cutoff = st_r.use_mc && (!st_r.pwm_en || !st_r.nmi_s2);

    // =========================================================
    // bus handshake
    assign req             = avs_read || avs_write;
    assign wr_go           = avs_write && !st_r.ack;
    assign rd_go           = avs_read && !st_r.ack;
    assign avs_waitrequest = req && !st_r.ack;
    assign avs_readdata    = st_r.rdata;
    assign pin_o           = st_r.pin_o;
    assign pin_oe          = st_r.pin_oe;

    // =========================================================
    // decode seen by the checks
    assign ctrl_wr = wr_go && avs_byteenable[0] &&
                     hit(avs_address, pfc_pkg::OFS_CTRL);
    assign mapped  = hit(avs_address, pfc_pkg::OFS_CTRL)  ||
                     hit(avs_address, pfc_pkg::OFS_FSEL)  ||
                     hit(avs_address, pfc_pkg::OFS_DIR)   ||
                     hit(avs_address, pfc_pkg::OFS_PDATA) ||
                     hit(avs_address, pfc_pkg::OFS_STATUS);
    assign wd_use  = avs_writedata[pfc_pkg::CTRL_USE_BIT];
    assign wd_en   = avs_writedata[pfc_pkg::CTRL_EN_BIT];

    // =========================================================
    // next state
    always_comb begin
        st_nxt = st_r;

        // two-stage synchronisers
        st_nxt.nmi_s1 = nmi_n;
        st_nxt.nmi_s2 = st_r.nmi_s1;
        st_nxt.pin_s1 = pin_i;
        st_nxt.pin_s2 = st_r.pin_s1;

        // one wait cycle, then accept
        st_nxt.ack = req && !st_r.ack;

        if (wr_go && avs_byteenable[0] &&
            hit(avs_address, pfc_pkg::OFS_CTRL)) begin
            st_nxt.use_mc = avs_writedata[pfc_pkg::CTRL_USE_BIT];
            st_nxt.pwm_en = avs_writedata[pfc_pkg::CTRL_EN_BIT];
        end
        if (wr_go && hit(avs_address, pfc_pkg::OFS_FSEL)) begin
            if (avs_byteenable[0]) begin
                st_nxt.fsel[7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                st_nxt.fsel[15:8] = avs_writedata[15:8];
            end
            if (avs_byteenable[2]) begin
                st_nxt.fsel[17:16] = avs_writedata[17:16];
            end
        end
        if (wr_go && avs_byteenable[0] &&
            hit(avs_address, pfc_pkg::OFS_DIR)) begin
            st_nxt.dir = avs_writedata[5:0];
        end
        if (wr_go && avs_byteenable[0] &&
            hit(avs_address, pfc_pkg::OFS_PDATA)) begin
            st_nxt.pdata = avs_writedata[5:0];
        end

        // emergency low wins over a software set
        // R6 hardware clears enable
        if (!st_r.nmi_s2) begin
            st_nxt.pwm_en = 1'b0;
        end

        if (rd_go) begin
            st_nxt.rdata = 32'h00000000;
            if (hit(avs_address, pfc_pkg::OFS_CTRL)) begin
                st_nxt.rdata[pfc_pkg::CTRL_USE_BIT] = st_r.use_mc;
                st_nxt.rdata[pfc_pkg::CTRL_EN_BIT]  = st_r.pwm_en;
            end else if (hit(avs_address, pfc_pkg::OFS_FSEL)) begin
                st_nxt.rdata[17:0] = st_r.fsel;
            end else if (hit(avs_address, pfc_pkg::OFS_DIR)) begin
                st_nxt.rdata[5:0] = st_r.dir;
            end else if (hit(avs_address, pfc_pkg::OFS_PDATA)) begin
                st_nxt.rdata[5:0] = st_r.pdata;
            end else if (hit(avs_address, pfc_pkg::OFS_STATUS)) begin
                st_nxt.rdata[pfc_pkg::ST_NMI_BIT] = st_r.nmi_s2;
                st_nxt.rdata[pfc_pkg::ST_CUT_BIT] = cutoff;
                st_nxt.rdata[pfc_pkg::ST_OE_LSB +: 6] = st_r.pin_oe;
                st_nxt.rdata[pfc_pkg::ST_PIN_LSB +: 6] = st_r.pin_s2;
            end
        end

        // pin drivers
        // R2 pass when unused
        // R4 pass when enabled
        st_nxt.pin_o  = sel_val;
        st_nxt.pin_oe = cutoff ? 6'h00 : out_mask;
    end

    // =========================================================
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r        <= '0;
            st_r.fsel   <= pfc_pkg::RST_FSEL;
            st_r.dir    <= pfc_pkg::RST_DIR;
            st_r.pdata  <= pfc_pkg::RST_PDATA;
            st_r.nmi_s1 <= pfc_pkg::RST_SYNC_N;
            st_r.nmi_s2 <= pfc_pkg::RST_SYNC_N;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_nmi_cut;
        st_r.use_mc && st_r.pwm_en && !st_r.nmi_s2;
    endsequence

    sequence s_floated;
        !st_r.pwm_en && (pin_oe == 6'h00);
    endsequence

    AST_NMI_CUT_CLEAR: assert property (s_nmi_cut |=> s_floated) // R6
        else $error("emergency low did not clear enable and float pins");

    AST_NMI_FLOAT: assert property (
        (st_r.use_mc && !st_r.nmi_s2) |=> (pin_oe == 6'h00)) // R5
        else $error("pins driven while emergency input low");

    AST_DISABLED_FLOAT: assert property (
        (st_r.use_mc && !st_r.pwm_en) |=> (pin_oe == 6'h00)) // R3
        else $error("pins driven while pwm output disabled");

    AST_UNUSED_PASS: assert property (
        !st_r.use_mc |=> (pin_oe == $past(out_mask)) &&
                         (pin_o == $past(sel_val))) // R2
        else $error("pin not following its function when unused");

    AST_ENABLED_PASS: assert property (
        (st_r.use_mc && st_r.pwm_en && st_r.nmi_s2) |=>
            (pin_oe == $past(out_mask)) && (pin_o == $past(sel_val))) // R4
        else $error("pin not following its function when enabled");

    AST_INPUT_UNDRIVEN: assert property (
        1'b1 |=> ((pin_oe & ~$past(out_mask)) == 6'h00)) // R1
        else $error("pin driven without an output function");

    AST_NMI_TWO_STAGE: assert property (
        $fell(nmi_n) && !st_r.ack |-> ##2 !st_r.nmi_s2) // R5
        else $error("emergency input not seen after two stages");

    AST_STAYS_OFF: assert property (
        (!st_r.pwm_en && !(avs_write && !st_r.ack)) |=> !st_r.pwm_en) // R6
        else $error("pwm enable set without a software write");

    AST_BUS_ONE_WAIT: assert property (
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer not given after one wait cycle");

    sequence s_new_req;
        $rose(req);
    endsequence

    AST_BUS_FIRST_WAIT: assert property (s_new_req |-> avs_waitrequest)
        else $error("fresh request answered without a wait cycle");

    AST_READ_STANDS: assert property (
        !rd_go |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    AST_UNMAPPED_ZERO: assert property (
        (rd_go && !mapped) |=> (avs_readdata == 32'h00000000))
        else $error("unmapped read returned nonzero data");

    // =========================================================
    // register side checks
    sequence s_ctrl_set;
        ctrl_wr && st_r.nmi_s2;
    endsequence

    sequence s_ctrl_taken;
        (st_r.use_mc == $past(wd_use)) && (st_r.pwm_en == $past(wd_en));
    endsequence

    AST_CTRL_WRITE_LANDS: assert property (s_ctrl_set |=> s_ctrl_taken) // R6
        else $error("control write not taken");

    AST_NMI_HOLDS_OFF: assert property (
        !st_r.nmi_s2 |=> !st_r.pwm_en) // R6
        else $error("pwm enable set while emergency input low");

    sequence s_nmi_seen;
        $fell(nmi_n) ##2 st_r.use_mc;
    endsequence

    AST_NMI_THREE_EDGES: assert property (
        s_nmi_seen |=> (pin_oe == 6'h00)) // R5
        else $error("pins not floated three edges after emergency low");

    AST_SYNC_ORDER: assert property (
        !st_r.nmi_s2 |-> ($past(st_r.nmi_s1) == 1'b0)) // R5
        else $error("emergency level skipped the first stage");

endmodule : pfc_cutoff

// ==== pfc_pkg.sv ====
package pfc_pkg;

    // =========================================================
    // geometry
    localparam int unsigned NPINS      = 6;
    localparam int unsigned FSEL_W     = 3;
    localparam int unsigned ADDR_W     = 5;
    localparam int unsigned DATA_W     = 32;

    // =========================================================
    // register byte offsets
    localparam logic [4:0] OFS_CTRL    = 5'h00;
    localparam logic [4:0] OFS_FSEL    = 5'h04;
    localparam logic [4:0] OFS_DIR     = 5'h08;
    localparam logic [4:0] OFS_PDATA   = 5'h0C;
    localparam logic [4:0] OFS_STATUS  = 5'h10;

    // =========================================================
    // field positions
    localparam int unsigned CTRL_USE_BIT  = 2;
    localparam int unsigned CTRL_EN_BIT   = 3;
    localparam int unsigned ST_NMI_BIT    = 0;
    localparam int unsigned ST_CUT_BIT    = 1;
    localparam int unsigned ST_OE_LSB     = 8;
    localparam int unsigned ST_PIN_LSB    = 16;

    // =========================================================
    // reset values
    localparam logic [5:0]  RST_DIR    = 6'h00;
    localparam logic [5:0]  RST_PDATA  = 6'h00;
    localparam logic [17:0] RST_FSEL   = 18'h00000;
    localparam logic        RST_SYNC_N = 1'b1;

    // =========================================================
    // pin function codes
    typedef enum logic [2:0] {
        PFC_FN_PORT   = 3'h0,
        PFC_FN_TIMER  = 3'h1,
        PFC_FN_PWM    = 3'h2,
        PFC_FN_SERIAL = 3'h3,
        PFC_FN_IIO    = 3'h4
    } pfc_fn_e;

    // output sources offered by the peripherals, one bit per pin
    typedef struct packed {
        logic [5:0] timer;
        logic [5:0] pwm;
        logic [5:0] serial;
        logic [5:0] iio;
    } pfc_fn_src_s;

    // whole block state
    typedef struct packed {
        logic        use_mc;
        logic        pwm_en;
        logic [17:0] fsel;
        logic [5:0]  dir;
        logic [5:0]  pdata;
        logic [5:0]  pin_o;
        logic [5:0]  pin_oe;
        logic        nmi_s1;
        logic        nmi_s2;
        logic [5:0]  pin_s1;
        logic [5:0]  pin_s2;
        logic        ack;
        logic [31:0] rdata;
    } pfc_state_s;

endpackage : pfc_pkg

// ==== pfc_stage_model.sv ====
`timescale 1ns/1ps
// =====================================================
// power stage seen from the gated pins
module pfc_stage_model (
    input  wire logic       clk,
    input  wire logic [5:0] pin_o,
    input  wire logic [5:0] pin_oe,
    output logic      [5:0] pin_i
);
    logic [5:0] last_r = 6'h00;

    always_ff @(posedge clk) begin
        last_r <= (pin_oe & pin_o) | (~pin_oe & last_r);
    end

    // a released line shows the inverse of its last driven level
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ~last_r);
endmodule : pfc_stage_model

// ==== tb_pwm_output_forced_cutoff.sv ====
`timescale 1ns/1ps
module tb_pwm_output_forced_cutoff;
    logic                 clk;
    logic                 rst;
    logic                 avs_read;
    logic                 avs_write;
    logic [4:0]           avs_address;
    logic [31:0]          avs_writedata;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic [3:0]           avs_byteenable = 4'hF;
    logic                 nmi_n;
    logic                 boot_select_pin;
    logic [5:0]           pin_i;
    logic [5:0]           pin_o;
    logic [5:0]           pin_oe;
    pfc_pkg::pfc_fn_src_s fn_src;
    logic [63:0]          expq[$];
    logic [63:0]          mon_e;
    logic [7:0]           lf;
    logic [5:0]           dir;
    logic [5:0]           pe;
    int                   fails;
    int                   samples_checked;

    pfc_cutoff dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fn_src(fn_src), .nmi_n(nmi_n), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe));
    pfc_stage_model stage_u (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_i(pin_i));

    // =====================================================
    // clock, monitor, watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            mon_e = expq.pop_front();
            samples_checked++;
            if ((avs_readdata & mon_e[63:32]) !== mon_e[31:0]) begin
                fails++;
                $display("ERROR readdata expected %h seen %h", mon_e[31:0],
                         avs_readdata & mon_e[63:32]);
            end
        end
    end

    initial begin
        #(50 * 20000);
        fails++;
        end_of_test();
    end

    // =====================================================
    // tasks
    task automatic rnd(output logic [7:0] r);
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        r = lf;
    endtask : rnd

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        logic w;
        int   n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            w = avs_waitrequest;
            n++;
        end while (w !== 1'b0 && n < 50);
        if (w !== 1'b0) begin
            fails++;
            $display("ERROR waitrequest expected 0 seen %b", w);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        expq.push_back({m, e & m});
        bus(1'b0, a, 32'h00000000);
    endtask : rd

    // set emergency level, write one register, then check pin state
    task automatic step(input logic [4:0] a, input logic [31:0] d,
                        input logic nm, input logic drv);
        logic [5:0] oe;
        oe = drv ? (dir & 6'h1F) : 6'h00;
        nmi_n <= nm;
        bus(1'b1, a, d);
        repeat (8) @(posedge clk);
        chk("pin_oe", {26'h0, oe}, {26'h0, pin_oe});
        chk("pin_o", {26'h0, pe & oe}, {26'h0, pin_o & oe});
        rd(pfc_pkg::OFS_STATUS, {10'h000, pe, 2'h0, oe, 6'h00, ~drv, nm},
           {10'h000, oe, 2'h0, 6'h3F, 6'h00, 1'b1, 1'b1});
    endtask : step

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, v);
        end
    endtask : chk

    task automatic end_of_test();
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // =====================================================
    // main sequence
    initial begin
        logic [7:0]           b;
        logic [5:0]           pd;
        pfc_pkg::pfc_fn_src_s s;
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h00000000;
        nmi_n = 1'b1;
        boot_select_pin = 1'b0;
        fn_src = '0;
        lf = 8'h52;
        fails = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        boot_select_pin <= 1'b1;
        chk("pin_oe", 32'h00000000, {26'h0, pin_oe});
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(pfc_pkg::OFS_CTRL, 32'h00000000, 32'hFFFFFFFF);
        bus(1'b1, 5'h14, 32'hFFFFFFFF);
        rd(5'h14, 32'h00000000, 32'hFFFFFFFF);
        // pins 0..4 take codes 0..4, pin 5 a non-output code
        bus(1'b1, pfc_pkg::OFS_FSEL, 32'h0002C688);
        rd(pfc_pkg::OFS_FSEL, 32'h0002C688, 32'h0003FFFF);
        avs_byteenable <= 4'hE;
        bus(1'b1, pfc_pkg::OFS_DIR, 32'hFFFFFFFF);
        avs_byteenable <= 4'hF;
        rd(pfc_pkg::OFS_DIR, 32'h00000000, 32'hFFFFFFFF);
        for (int r = 0; r < 3; r++) begin
            rnd(b);
            dir = b[5:0];
            rnd(b);
            pd = b[5:0];
            rnd(b);
            s[23:16] = b;
            rnd(b);
            s[15:8] = b;
            rnd(b);
            s[7:0] = b;
            fn_src <= s;
            pe = {1'b0, s.iio[4], s.serial[3], s.pwm[2], s.timer[1], pd[0]};
            bus(1'b1, pfc_pkg::OFS_DIR, {26'h0, dir});
            bus(1'b1, pfc_pkg::OFS_PDATA, {26'h0, pd});
            step(pfc_pkg::OFS_CTRL, 32'h00000000, 1'b0, 1'b1);
            step(pfc_pkg::OFS_CTRL, 32'h00000004, 1'b1, 1'b0);
            step(pfc_pkg::OFS_CTRL, 32'h0000000C, 1'b1, 1'b1);
            step(pfc_pkg::OFS_CTRL, 32'h0000000C, 1'b0, 1'b0);
            rd(pfc_pkg::OFS_CTRL, 32'h00000004, 32'h0000000C);
            step(pfc_pkg::OFS_PDATA, {26'h0, pd}, 1'b1, 1'b0);
            step(pfc_pkg::OFS_CTRL, 32'h0000000C, 1'b1, 1'b1);
        end
        end_of_test();
    end
endmodule : tb_pwm_output_forced_cutoff
